/* rtl/tpo_timer_prescaler_option_control.sv */
`include "tpo_defines.svh"
// Overview of operation
// - The config word is read/write and all eight bits reset to one.
// - The config word answers at two mirrored addresses sharing one register.
// - Bit 7 high disables all port B pull-ups, low enables each by its latch bit.
// - Bit 6 high raises the external interrupt on a rising edge, low on a falling edge.
// - Bit 5 high counts the external clock pin, low counts the instruction cycle clock.
// - Bit 4 high counts high-to-low pin transitions, low counts low-to-high ones.
// - Bit 3 high gives the prescaler to the watchdog, low gives it to the timer.
// - On the timer the rate codes divide by 2 at 000 doubling up to 256 at 111.
// - On the watchdog the rate codes divide by 1 at 000 doubling up to 128 at 111.
// - Port A bit 4 is the external timer clock input and its driver only pulls low.
module tpo_timer_prescaler_option_control
  import tpo_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire tpo_addr_t paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire tpo_byte_t portBLatch,
  output tpo_byte_t portBPullupEn,
  input wire logic extInterruptPin,
  output logic extIrqEvent,
  input wire logic extTimerClockIn,
  input wire logic portA4Latch,
  input wire logic portA4DirIn,
  output logic extTimerClockOut,
  output logic extTimerClockOe,
  input wire logic watchdogTick,
  output logic watchdogTimeout,
  output tpo_byte_t timerZeroCount,
  output logic timerOverflow
);

  // ************************************************
  // APB decode
  // ************************************************
  localparam tpo_addr_t CfgAddrLo = 12'(`TPO_CFG_INDEX_LO << 2);
  localparam tpo_addr_t CfgAddrHi = 12'(`TPO_CFG_INDEX_HI << 2);
  localparam tpo_addr_t CntAddr = 12'(`TPO_CNT_INDEX << 2);

  tpo_byte_t cfg_reg;
  tpo_byte_t cnt_reg;
  tpo_byte_t pre_reg;
  tpo_byte_t pre_next;
  logic [1:0] cyc_reg;
  logic extPinPrev_reg;
  logic irqPinPrev_reg;
  logic psaPrev_reg;
  logic [31:0] rdata_reg;
  logic err_reg;
  logic hitCfg;
  logic hitCnt;
  logic setup;
  logic access;
  logic cfgWrite;
  logic cntWrite;
  logic instrTick;
  logic extRise;
  logic extFall;
  logic extTick;
  logic srcTick;
  logic preTick;
  logic preDone;
  tpo_byte_t preMask;
  tpo_rate_t rate;
  tpo_assign_t prescalerSel;
  logic assignChange;
  logic timerStep;
  logic watchdogStep;

  // Both mirrored addresses decode to the one config word
  always_comb begin
    hitCfg = 1'b0;
    if ((paddr == CfgAddrLo) || (paddr == CfgAddrHi)) begin
      hitCfg = 1'b1;
    end
  end

  assign hitCnt = (paddr == CntAddr);
  assign setup = psel && !penable;
  assign access = psel && penable;
  assign pready = 1'b1;
  assign cfgWrite = access && pwrite && hitCfg;
  assign cntWrite = access && pwrite && hitCnt;

  // ************************************************
  // Read data and error, captured in setup
  // ************************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_reg <= 32'h00000000;
      err_reg <= 1'b0;
    end else if (setup) begin
      err_reg <= !(hitCfg || hitCnt);
      if (pwrite) begin
        rdata_reg <= 32'h00000000;
      end else if (hitCfg) begin
        rdata_reg <= {`TPO_WORD_PAD, cfg_reg};
      end else if (hitCnt) begin
        rdata_reg <= {`TPO_WORD_PAD, cnt_reg};
      end else begin
        rdata_reg <= 32'h00000000;
      end
    end
  end

  assign prdata = rdata_reg;
  assign pslverr = access && err_reg;

  // ************************************************
  // Config word
  // ************************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_reg <= `TPO_CFG_RESET;
    end else if (cfgWrite) begin
      cfg_reg <= pwdata[7:0];
    end
  end

  assign rate = cfg_reg[`TPO_RATE_MSB:`TPO_RATE_LSB];
  assign prescalerSel = tpo_assign_t'(cfg_reg[`TPO_ASSIGN_BIT]);

  // ************************************************
  // Port B pull-ups
  // ************************************************
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_pullup
      assign portBPullupEn[gi] = !cfg_reg[`TPO_PULLUP_DIS_BIT] && portBLatch[gi];
    end
  endgenerate

  // ************************************************
  // External interrupt edge
  // ************************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irqPinPrev_reg <= 1'b0;
      extIrqEvent <= 1'b0;
    end else begin
      irqPinPrev_reg <= extInterruptPin;
      if (cfg_reg[`TPO_IRQ_EDGE_BIT]) begin
        extIrqEvent <= extInterruptPin && !irqPinPrev_reg;
      end else begin
        extIrqEvent <= !extInterruptPin && irqPinPrev_reg;
      end
    end
  end

  // ************************************************
  // Open-drain external clock pin
  // ************************************************
  assign extTimerClockOut = 1'b0;
  assign extTimerClockOe = !portA4DirIn && !portA4Latch;

  // ************************************************
  // Instruction cycle divider
  // ************************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cyc_reg <= `TPO_CYC_ZERO;
    end else begin
      cyc_reg <= cyc_reg + `TPO_CYC_ONE;
    end
  end

  assign instrTick = (cyc_reg == `TPO_CYC_LAST);

  // ************************************************
  // Timer source selection
  // ************************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      extPinPrev_reg <= 1'b0;
    end else begin
      extPinPrev_reg <= extTimerClockIn;
    end
  end

  assign extRise = extTimerClockIn && !extPinPrev_reg;
  assign extFall = !extTimerClockIn && extPinPrev_reg;
  always_comb begin
    if (cfg_reg[`TPO_SRC_EDGE_BIT]) begin
      extTick = extFall;
    end else begin
      extTick = extRise;
    end
  end

  always_comb begin
    if (cfg_reg[`TPO_CLK_SRC_BIT]) begin
      srcTick = extTick;
    end else begin
      srcTick = instrTick;
    end
  end

  // ************************************************
  // Shared prescaler
  // ************************************************
  always_comb begin
    if (prescalerSel == TPO_ASSIGN_WDOG) begin
      preTick = watchdogTick;
    end else begin
      preTick = srcTick;
    end
  end

  always_comb begin
    if (prescalerSel == TPO_ASSIGN_WDOG) begin
      preMask = 8'((`TPO_WDOG_BASE << rate) - `TPO_ONE9);
    end else begin
      preMask = 8'((`TPO_TMR_BASE << rate) - `TPO_ONE9);
    end
  end

  assign preDone = preTick && (pre_reg >= preMask);

  always_comb begin
    pre_next = pre_reg;
    if (preDone) begin
      pre_next = `TPO_PRE_ZERO;
    end else if (preTick) begin
      pre_next = pre_reg + `TPO_PRE_ONE;
    end
  end

  assign assignChange = (psaPrev_reg != cfg_reg[`TPO_ASSIGN_BIT]);

  // Reassignment or a timer load restarts the division period
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pre_reg <= `TPO_PRE_ZERO;
      psaPrev_reg <= 1'b1;
    end else begin
      psaPrev_reg <= cfg_reg[`TPO_ASSIGN_BIT];
      if (cntWrite || assignChange) begin
        pre_reg <= `TPO_PRE_ZERO;
      end else begin
        pre_reg <= pre_next;
      end
    end
  end

  // ************************************************
  // Watchdog postscaler output
  // ************************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      watchdogTimeout <= 1'b0;
    end else begin
      watchdogTimeout <= watchdogStep;
    end
  end

  // ************************************************
  // Step selection
  // ************************************************
  // Without the prescaler the timer takes every source tick
  always_comb begin
    timerStep = 1'b0;
    watchdogStep = 1'b0;
    if (prescalerSel == TPO_ASSIGN_WDOG) begin
      timerStep = srcTick;
      watchdogStep = preDone;
    end else begin
      timerStep = preDone;
    end
  end

  // ************************************************
  // Timer count
  // ************************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_reg <= `TPO_CNT_RESET;
      timerOverflow <= 1'b0;
    end else begin
      timerOverflow <= 1'b0;
      if (cntWrite) begin
        cnt_reg <= pwdata[7:0];
      end else if (timerStep) begin
        cnt_reg <= cnt_reg + `TPO_PRE_ONE;
        timerOverflow <= (cnt_reg == `TPO_CFG_RESET);
      end
    end
  end

  assign timerZeroCount = cnt_reg;

endmodule : tpo_timer_prescaler_option_control

/* rtl/tpo_defines.svh */
`ifndef TPO_DEFINES_SVH
`define TPO_DEFINES_SVH
// ************************************************
// Register map
// ************************************************
`define TPO_CFG_INDEX_LO 12'h081
`define TPO_CFG_INDEX_HI 12'h181
`define TPO_CNT_INDEX 12'h001
`define TPO_CFG_RESET 8'hFF
`define TPO_CNT_RESET 8'h00
// ************************************************
// Config word fields
// ************************************************
`define TPO_PULLUP_DIS_BIT 7
`define TPO_IRQ_EDGE_BIT 6
`define TPO_CLK_SRC_BIT 5
`define TPO_SRC_EDGE_BIT 4
`define TPO_ASSIGN_BIT 3
`define TPO_RATE_MSB 2
`define TPO_RATE_LSB 0
// ************************************************
// Prescaler and divider constants
// ************************************************
`define TPO_TMR_BASE 9'h002
`define TPO_WDOG_BASE 9'h001
`define TPO_ONE9 9'h001
`define TPO_PRE_ZERO 8'h00
`define TPO_PRE_ONE 8'h01
`define TPO_CYC_LAST 2'h3
`define TPO_CYC_ONE 2'h1
`define TPO_CYC_ZERO 2'h0
`define TPO_WORD_PAD 24'h000000
`endif

/* rtl/tpo_pkg.sv */
`include "tpo_defines.svh"
// ************************************************
// Shared types
// ************************************************
package tpo_pkg;
  typedef logic [7:0] tpo_byte_t;
  typedef logic [2:0] tpo_rate_t;
  typedef logic [11:0] tpo_addr_t;
  typedef enum logic {
    TPO_ASSIGN_TIMER = 1'b0,
    TPO_ASSIGN_WDOG = 1'b1
  } tpo_assign_t;
endpackage : tpo_pkg

/* tb/tpo_ext_source.sv */
// ********
// External timer clock pin and watchdog base tick
// ********
module tpo_ext_source #(
  parameter int halfPeriod = 10,
  parameter int wdtGap = 3
) (
  input wire logic clk,
  input wire logic reset_n,
  output logic pinDrive,
  output logic watchdogTick
);
  timeunit 1ns;
  timeprecision 1ns;
  int pinCnt;
  int tickCnt;
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pinCnt <= 0;
      tickCnt <= 0;
      pinDrive <= 1'h0;
      watchdogTick <= 1'h0;
    end else begin
      pinCnt <= (pinCnt == halfPeriod - 1) ? 0 : pinCnt + 1;
      tickCnt <= (tickCnt == wdtGap - 1) ? 0 : tickCnt + 1;
      pinDrive <= (pinCnt == halfPeriod - 1) ? !pinDrive : pinDrive;
      watchdogTick <= (tickCnt == wdtGap - 1);
    end
  end
endmodule : tpo_ext_source

/* tb/tpo_option_sva.sv */
`include "tpo_defines.svh"
// ********
// Port checker
// ********
module tpo_option_chk
  import tpo_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire tpo_addr_t paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire tpo_byte_t portBLatch,
  input wire tpo_byte_t portBPullupEn,
  input wire logic extInterruptPin,
  input wire logic extIrqEvent,
  input wire logic watchdogTick,
  input wire logic watchdogTimeout,
  input wire tpo_byte_t timerZeroCount,
  input wire logic timerOverflow
);
  tpo_byte_t cfg_reg;
  logic pin_reg;
  logic acc;
  logic hit;
  assign acc = psel && penable;
  assign hit = paddr == (`TPO_CFG_INDEX_LO << 2) || paddr == (`TPO_CFG_INDEX_HI << 2);
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_reg <= `TPO_CFG_RESET;
      pin_reg <= 1'h0;
    end else begin
      pin_reg <= extInterruptPin;
      cfg_reg <= (acc && pwrite && hit) ? pwdata[7:0] : cfg_reg;
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  property p_pull; portBPullupEn == (cfg_reg[7] ? 8'h00 : portBLatch); endproperty
  a_pull: assert property (p_pull) else $error("pull-up enables wrong");
  property p_irq;
    extIrqEvent == $past(extInterruptPin != pin_reg && extInterruptPin == cfg_reg[6]);
  endproperty
  a_irq: assert property (p_irq) else $error("edge event wrong");
  property p_err; acc |-> pslverr == !(hit || paddr == (`TPO_CNT_INDEX << 2)); endproperty
  a_err: assert property (p_err) else $error("error response wrong");
  property p_rd; acc && !pwrite && hit |-> prdata == {24'h000000, cfg_reg}; endproperty
  a_rd: assert property (p_rd) else $error("config read wrong");
  property p_wdt; watchdogTick && cfg_reg[3:0] == 4'h8 |=> watchdogTimeout; endproperty
  a_wdt: assert property (p_wdt) else $error("postscale 1:1 missed");
  property p_wdtCause; watchdogTimeout |-> $past(watchdogTick); endproperty
  a_wdtCause: assert property (p_wdtCause) else $error("timeout without tick");
  property p_ovf; timerOverflow |-> timerZeroCount == 8'h00 && $past(timerZeroCount) == 8'hFF;
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow wrong");
  property p_step; $changed(timerZeroCount) && !$past(acc && pwrite)
    |-> timerZeroCount == $past(timerZeroCount) + 8'h01; endproperty
  a_step: assert property (p_step) else $error("count step wrong");
endmodule : tpo_option_chk
bind tpo_timer_prescaler_option_control tpo_option_chk chk (
  .clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pslverr,
  .portBLatch, .portBPullupEn, .extInterruptPin, .extIrqEvent, .watchdogTick,
  .watchdogTimeout, .timerZeroCount, .timerOverflow
);

/* tb/tpo_timer_prescaler_option_control_bench.sv */
`include "tpo_defines.svh"
// ********
// Register access bench
// ********
module tpo_timer_prescaler_option_control_bench
  import tpo_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam tpo_addr_t cfgLo = tpo_addr_t'(`TPO_CFG_INDEX_LO << 2);
  localparam tpo_addr_t cfgHi = tpo_addr_t'(`TPO_CFG_INDEX_HI << 2);
  localparam tpo_addr_t cntAddr = tpo_addr_t'(`TPO_CNT_INDEX << 2);
  localparam int halfPeriod = 10;
  localparam int wdtGap = 3;
  logic clk = 1'h0, reset_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  tpo_addr_t paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  // Latch bit 3 kept clear so that pin's pull-up stays off
  tpo_byte_t portBLatch = 8'hC3, portBPullupEn, timerZeroCount, rd;
  logic extInterruptPin = 1'h0, portA4Latch = 1'h1, portA4DirIn = 1'h1, err;
  logic pready, pslverr, extIrqEvent, extTimerClockOut, extTimerClockOe, extTimerClockIn;
  logic pinDrive, watchdogTick, watchdogTimeout, timerOverflow;
  int mismatches = 0, checks = 0, irqs = 0, want = 0, c;
  // Open-drain pin: low whenever the block pulls it
  assign extTimerClockIn = pinDrive & !extTimerClockOe;
  always #50 clk = ~clk;
  always @(posedge clk) irqs <= irqs + (extIrqEvent === 1'h1 ? 1 : 0);
  tpo_timer_prescaler_option_control dut (
    .clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .portBLatch, .portBPullupEn, .extInterruptPin, .extIrqEvent,
    .extTimerClockIn, .portA4Latch, .portA4DirIn, .extTimerClockOut, .extTimerClockOe,
    .watchdogTick, .watchdogTimeout, .timerZeroCount, .timerOverflow
  );
  tpo_ext_source #(.halfPeriod(halfPeriod), .wdtGap(wdtGap)) src (
    .clk, .reset_n, .pinDrive, .watchdogTick
  );
  task automatic stop_test();
    if (mismatches == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input tpo_addr_t a, input tpo_byte_t d);
    int n;
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {`TPO_WORD_PAD, d};
    @(posedge clk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'h1 && n < 16);
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    if (n >= 16) begin
      mismatches++;
      stop_test();
    end
  endtask : apb
  task automatic gap(input logic wdt, output int c);
    tpo_byte_t last;
    logic ev;
    c = 0;
    last = timerZeroCount;
    do begin
      @(negedge clk);
      c++;
      ev = wdt ? watchdogTimeout : timerZeroCount !== last;
      last = timerZeroCount;
    end while (ev !== 1'h1 && c < 4000);
    if (ev !== 1'h1) begin
      mismatches++;
      stop_test();
    end
  endtask : gap
  initial begin
    repeat (20) @(posedge clk);
    reset_n <= 1'h1;
    apb(1'h0, cfgHi, 8'h00);
    chk(rd, `TPO_CFG_RESET);
    chk(portBPullupEn, 8'h00);
    apb(1'h0, 12'h100, 8'h00);
    chk(err, 1'h1);
    apb(1'h1, cfgHi, 8'h5A);
    apb(1'h0, cfgLo, 8'h00);
    chk(rd, 8'h5A);
    chk(portBPullupEn, 8'hC3);
    for (int r = 0; r < 8; r++) begin
      apb(1'h1, cfgLo, {5'h00, r[2:0]});
      gap(1'h0, c);
      gap(1'h0, c);
      chk(c, 4 * (2 << r));
      apb(1'h1, cfgHi, {5'h01, r[2:0]});
      gap(1'h1, c);
      gap(1'h1, c);
      chk(c, wdtGap * (1 << r));
    end
    apb(1'h1, cfgLo, 8'h08);
    gap(1'h0, c);
    gap(1'h0, c);
    chk(c, 4);
    // Load near the top and wait for the wrap
    apb(1'h1, cntAddr, 8'hFE);
    @(negedge clk);
    chk(timerZeroCount, 8'hFE);
    for (int k = 0; k < 4 && timerZeroCount !== 8'h00; k++) begin
      gap(1'h0, c);
    end
    chk(timerZeroCount, 8'h00);
    chk(timerOverflow, 1'h1);
    for (int e = 0; e < 2; e++) begin
      apb(1'h1, cfgLo, {3'h1, e[0], 4'h8});
      gap(1'h0, c);
      gap(1'h0, c);
      chk(c, 2 * halfPeriod);
      chk(extTimerClockIn, !e[0]);
    end
    for (int e = 1; e >= 0; e--) begin
      apb(1'h1, cfgHi, {1'h0, e[0], 6'h08});
      for (int k = 0; k < 4; k++) begin
        extInterruptPin <= !extInterruptPin;
        repeat (3) @(posedge clk);
        want = want + (extInterruptPin === e[0] ? 1 : 0);
        chk(irqs, want);
      end
    end
    portA4DirIn <= 1'h0;
    portA4Latch <= 1'h0;
    repeat (2) @(posedge clk);
    chk({extTimerClockOe, extTimerClockOut}, 2'h2);
    stop_test();
  end
endmodule : tpo_timer_prescaler_option_control_bench
